// ### rtl/sscs_slave.sv
// Serial command slave with page pointer, memory port and AHB-Lite status registers
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Sixteen-bit words, most significant bit first
// - Fields: 3-bit identifier, 5-bit address, 8-bit data
// - Execute now, reply during next frame
// - Select rising edge ends and executes command
// - Sample input bit on clock rise
// - First bit at select fall, shift on fall
// - Serial output always driven, never floated
// - All-zero identifier is no-operation poll
// - Identifier 001 reads byte in page
// - Identifier 010 writes byte in page
// - Abort command stops pending work, idles
// - Page command loads persistent 3-bit pointer
// - Page selects 32-byte window, default zero
// - Reset command reloads memory, then idles
// - Busy device drops newly received commands except abort
// - Idle, read-done, write-done reply encodings
// - Fixed read and write not-done replies
// - Identifier 111 status replies, four patterns
// - Page reply carries page in address
module sscs_slave
  import sscs_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sclk,
  input wire logic frame_select_low,
  input wire logic mosi,
  output logic miso,
  output logic mem_req,
  output logic mem_we,
  output logic [7:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  output logic reload_req,
  input wire logic reload_done
);
  // ****************************************
  // Pin synchronisers and edge finding
  // ****************************************
  logic [2:0] sclk_q; // Stage 0 feeds stage 1 only
  logic [2:0] ss_q;
  logic [1:0] mosi_q;
  logic sclk_rise;
  logic sclk_fall;
  logic ss_fall;
  logic ss_rise;

  // Two flops per pin, third stage only for edge finding
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sclk_q <= 3'h0;
      ss_q <= 3'h7;
      mosi_q <= 2'h0;
    end
    else
    begin
      sclk_q <= {sclk_q[1:0], sclk};
      ss_q <= {ss_q[1:0], frame_select_low};
      mosi_q <= {mosi_q[0], mosi};
    end
  end

  assign sclk_rise = sclk_q[1] && !sclk_q[2];
  assign sclk_fall = !sclk_q[1] && sclk_q[2];
  assign ss_fall = !ss_q[1] && ss_q[2];
  assign ss_rise = ss_q[1] && !ss_q[2];

  // ****************************************
  // Shift registers
  // ****************************************
  logic [15:0] rx_q; // Incoming command word
  logic [15:0] tx_q; // Outgoing reply word
  logic [4:0] cnt_q; // Rising edges seen in this frame
  logic [15:0] resp_q; // Reply for the next frame

  // Receive side, capture on each clock rise inside a frame
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_q <= 16'h0000;
      cnt_q <= 5'h00;
    end
    else if (ss_fall)
    begin
      cnt_q <= 5'h00;
    end
    else if (sclk_rise && !ss_q[1])
    begin
      rx_q <= {rx_q[14:0], mosi_q[1]};
      // Saturate so an overlong frame still reads as wrong length
      if (cnt_q <= FRAME_BITS)
      begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  // Transmit side, load at select fall, advance on clock fall
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_q <= 16'h0000;
    end
    else if (ss_fall)
    begin
      tx_q <= resp_q;
    end
    else if (sclk_fall && !ss_q[1])
    begin
      tx_q <= {tx_q[14:0], 1'b0};
    end
  end

  // Output is a flop bit and always driven; a single slave only
  assign miso = tx_q[15];

  // ****************************************
  // Command decode
  // ****************************************
  logic [2:0] command_identifier;
  logic [4:0] command_address;
  logic [7:0] command_payload;
  logic accept;
  logic fields_zero;
  logic boot_ready_q;
  logic busy;
  sscs_pend_e pend_q;
  logic [2:0] page_q;

  assign command_identifier = rx_q[ID_MSB:ID_LSB];
  assign command_address = rx_q[ADDR_MSB:ADDR_LSB];
  assign command_payload = rx_q[DATA_MSB:0];
  assign fields_zero = (command_address == 5'h00) && (command_payload == 8'h00);
  assign accept = ss_rise && (cnt_q == FRAME_BITS);
  assign busy = (pend_q != PEND_NONE);

  // Pending operation, reply word and memory port
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_q <= PEND_NONE;
      resp_q <= REPLY_IDLE;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 8'h00;
      mem_wdata <= 8'h00;
      reload_req <= 1'b0;
    end
    else
    begin
      reload_req <= 1'b0;
      // Completion is handled first, so a frame ending in the same cycle
      // cannot swallow the one-cycle acknowledge and leave the port busy
      case (pend_q)
        PEND_READ:
        begin
          if (mem_ack)
          begin
            pend_q <= PEND_NONE;
            mem_req <= 1'b0;
            resp_q <= {RID_READ, mem_addr[4:0], mem_rdata};
          end
        end
        PEND_WRITE:
        begin
          if (mem_ack)
          begin
            pend_q <= PEND_NONE;
            mem_req <= 1'b0;
            resp_q <= {RID_WRITE, mem_addr[4:0], mem_wdata};
          end
        end
        PEND_RELOAD:
        begin
          if (reload_done)
          begin
            pend_q <= PEND_NONE;
            resp_q <= REPLY_IDLE;
          end
        end
        default:
        begin
          pend_q <= PEND_NONE;
        end
      endcase
      // Frame handling below overrides the completion reply where both fall together, except for a dropped command
      if (ss_rise && (cnt_q != FRAME_BITS))
      begin
        // Wrong length: report it, no access started
        resp_q <= REPLY_BUS_ERROR;
      end
      else if (accept && !boot_ready_q)
      begin
        resp_q <= BOOT_UNREADY_REPLY;
      end
      else if (accept && busy)
      begin
        // Only an abort gets through while busy
        if (command_identifier == CID_ABORT && fields_zero)
        begin
          pend_q <= PEND_NONE;
          mem_req <= 1'b0;
          resp_q <= ABORT_COMPLETE_REPLY;
        end
        // Anything else is dropped, reply keeps its current value
      end
      else if (accept)
      begin
        case (command_identifier)
          CID_NOP:
          begin
            resp_q <= fields_zero ? REPLY_IDLE : REPLY_BUS_ERROR;
          end
          CID_READ:
          begin
            // Data field is expected zero; it is not checked
            pend_q <= PEND_READ;
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= {page_q, command_address};
            resp_q <= REPLY_READ_WAIT;
          end
          CID_WRITE:
          begin
            pend_q <= PEND_WRITE;
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= {page_q, command_address};
            mem_wdata <= command_payload;
            resp_q <= REPLY_WRITE_WAIT;
          end
          CID_ABORT:
          begin
            resp_q <= fields_zero ? ABORT_COMPLETE_REPLY : REPLY_BUS_ERROR;
          end
          CID_PAGE:
          begin
            resp_q <= {RID_PAGE, 2'h0, command_address[PAGE_MSB:0], 8'h00};
          end
          CID_RESET:
          begin
            if (fields_zero)
            begin
              pend_q <= PEND_RELOAD;
              reload_req <= 1'b1;
              resp_q <= REPLY_IF_UNREADY;
            end
            else
            begin
              resp_q <= REPLY_BUS_ERROR;
            end
          end
          default:
          begin
            resp_q <= REPLY_BUS_ERROR;
          end
        endcase
      end
    end
  end

  // Page pointer persists until the next page command
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      page_q <= PAGE_RESET;
    end
    else if (accept && boot_ready_q && !busy && command_identifier == CID_PAGE)
    begin
      page_q <= command_address[PAGE_MSB:0];
    end
  end

  // ****************************************
  // AHB-Lite register slave
  // ****************************************
  logic [15:0] last_cmd_q; // Last complete command word
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic addr_ok;

  assign hreadyout = 1'b1; // Zero wait states
  assign hresp = 1'b0; // Always OKAY
  assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);

  // Last command capture for software inspection
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      last_cmd_q <= 16'h0000;
    end
    else if (accept)
    begin
      last_cmd_q <= rx_q;
    end
  end

  // Address phase capture, write in data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      boot_ready_q <= CTRL_BOOT_RESET;
    end
    else
    begin
      wr_pend_q <= addr_ok && hwrite;
      if (addr_ok)
      begin
        wr_addr_q <= haddr[7:0];
      end
      // Boot ready gates every full-length command; wrong-length frames still get the error reply
      if (wr_pend_q && wr_addr_q == REG_CTRL)
      begin
        boot_ready_q <= hwdata[CTRL_BOOT_BIT];
      end
    end
  end

  // Read data prepared in the address phase; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h00000000;
    end
    else if (addr_ok && !hwrite)
    begin
      case (haddr[7:0])
        REG_CTRL: hrdata <= {31'h00000000, boot_ready_q};
        REG_STATUS: hrdata <= {26'h0000000, pend_q, busy, page_q};
        REG_LAST_CMD: hrdata <= {16'h0000, last_cmd_q};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  miso_first_a: assert property (ss_fall |=> miso == $past(resp_q[15]))
    else $error("first reply bit not presented at select fall");
  bit_sample_a: assert property (sclk_rise && !ss_q[1] |=> rx_q[0] == $past(mosi_q[1]))
    else $error("input bit not sampled on clock rise");
  page_load_a: assert property (accept && boot_ready_q && !busy && command_identifier == CID_PAGE
    |=> page_q == $past(command_address[2:0]) && resp_q[15:13] == RID_PAGE)
    else $error("page pointer not loaded");
  busy_drop_a: assert property (accept && busy && command_identifier != CID_ABORT |=> $stable(page_q) && $stable(mem_addr))
    else $error("command taken while busy");
  abort_idle_a: assert property (accept && boot_ready_q && command_identifier == CID_ABORT && fields_zero
    |=> !busy && !mem_req && resp_q == ABORT_COMPLETE_REPLY)
    else $error("abort did not return to idle");
  reserved_err_a: assert property (accept && boot_ready_q && !busy && (command_identifier == 3'h5 || command_identifier == 3'h7)
    |=> resp_q == REPLY_BUS_ERROR && !mem_req)
    else $error("reserved identifier not flagged");
  length_err_a: assert property (ss_rise && cnt_q != FRAME_BITS |=> resp_q == REPLY_BUS_ERROR)
    else $error("wrong frame length not flagged");
  write_issue_a: assert property (accept && boot_ready_q && !busy && command_identifier == CID_WRITE
    |=> mem_req && mem_we && mem_addr == {page_q, $past(command_address)} && resp_q == REPLY_WRITE_WAIT)
    else $error("write not issued in page");
  read_done_a: assert property (pend_q == PEND_READ && mem_ack && !accept && !ss_rise
    |=> resp_q == {RID_READ, $past(mem_addr[4:0]), $past(mem_rdata)} && !busy)
    else $error("read done reply wrong");
  read_wait_a: assert property (accept && boot_ready_q && !busy && command_identifier == CID_READ
    |=> resp_q == REPLY_READ_WAIT && mem_req && !mem_we)
    else $error("read not-done reply wrong");
  ack_done_a: assert property (busy && pend_q != PEND_RELOAD && mem_ack |=> !busy)
    else $error("memory acknowledge lost");

  read_cov_c: cover property (accept && command_identifier == CID_READ ##[1:50] mem_ack);
  drop_cov_c: cover property (accept && busy && command_identifier == CID_READ);
  reload_cov_c: cover property (reload_req ##[1:100] reload_done);
endmodule
`default_nettype wire

// ### rtl/sscs_pkg.sv
// Constants shared by the sensor serial command slave
package sscs_pkg;
  // ****************************************
  // Frame layout
  // ****************************************
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam int ID_MSB = 15;
  localparam int ID_LSB = 13;
  localparam int ADDR_MSB = 12;
  localparam int ADDR_LSB = 8;
  localparam int DATA_MSB = 7;
  localparam int PAGE_MSB = 2;
  // ****************************************
  // Command identifiers
  // ****************************************
  localparam logic [2:0] CID_NOP = 3'h0;
  localparam logic [2:0] CID_READ = 3'h1;
  localparam logic [2:0] CID_WRITE = 3'h2;
  localparam logic [2:0] CID_ABORT = 3'h3;
  localparam logic [2:0] CID_PAGE = 3'h4;
  localparam logic [2:0] CID_RESET = 3'h6;
  // ****************************************
  // Reply identifiers and fixed replies
  // ****************************************
  localparam logic [2:0] RID_READ = 3'h1;
  localparam logic [2:0] RID_WRITE = 3'h2;
  localparam logic [2:0] RID_PAGE = 3'h4;
  localparam logic [15:0] REPLY_IDLE = 16'h0000;
  localparam logic [15:0] REPLY_READ_WAIT = 16'h7333;
  localparam logic [15:0] REPLY_WRITE_WAIT = 16'hCCCC;
  localparam logic [15:0] BOOT_UNREADY_REPLY = 16'hEBFF;
  localparam logic [15:0] ABORT_COMPLETE_REPLY = 16'hE38E;
  localparam logic [15:0] REPLY_BUS_ERROR = 16'hF5FF;
  localparam logic [15:0] REPLY_IF_UNREADY = 16'hFFFF;
  localparam logic [2:0] PAGE_RESET = 3'h0;
  // ****************************************
  // Register map on the AHB-Lite side
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LAST_CMD = 8'h08;
  localparam int CTRL_BOOT_BIT = 0;
  localparam logic CTRL_BOOT_RESET = 1'b0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // ****************************************
  // Pending operation states
  // ****************************************
  typedef enum logic [1:0] {PEND_NONE, PEND_READ, PEND_WRITE, PEND_RELOAD} sscs_pend_e;
endpackage

// ### sim/sscs_spi_master.sv
// Serial bus master model that frames commands and collects replies
`timescale 1ns/1ps
`default_nettype none
module sscs_spi_master (
  output logic sclk,
  output logic frame_select_low,
  output logic mosi,
  input wire logic miso
);
  // Idle: clock parked low, select high
  initial
  begin
    sclk = 1'b0;
    frame_select_low = 1'b1;
    mosi = 1'b0;
  end
  // One frame of n bits, MSB first; n other than 16 is a deliberate framing fault
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    frame_select_low = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      // Data changes while the clock is low, 80 ns period
      mosi = w[15 - i];
      #40 sclk = 1'b1;
      // Sampled late in the high phase: the reply bit crosses a synchroniser first
      #38 r = {r[14:0], miso};
      #2 sclk = 1'b0;
    end
    #40 frame_select_low = 1'b1;
    // Released data line must not keep showing the last bit
    mosi = ~mosi;
    #100;
  endtask
endmodule
`default_nettype wire

// ### sim/sensor_spi_command_slave_tb_top.sv
// Self-checking bench for the serial command slave
`timescale 1ns/1ps
`default_nettype none
module sensor_spi_command_slave_tb_top;
  import sscs_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic sclk, fsl, mosi, miso, mem_req, mem_we, mem_ack, reload_req, reload_done;
  logic [7:0] mem_addr, mem_wdata, mem_rdata, seen_addr, seen_wdata;
  logic seen_we;
  logic [15:0] r;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  int mem_delay = 2;
  int mem_cnt = 0;
  int reload_cnt = 0;
  int acks = 0;
  int reload_wait = 0;
  sscs_slave DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sclk(sclk), .frame_select_low(fsl), .mosi(mosi),
    .miso(miso), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .reload_req(reload_req), .reload_done(reload_done));
  sscs_spi_master m (.sclk(sclk), .frame_select_low(fsl), .mosi(mosi), .miso(miso));
  // ****************************************
  // Clock, timeout and far-side memory
  // ****************************************
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // Memory answers after mem_delay cycles; byte read back is address xor 3C
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    mem_ack <= 1'b0;
    // Reload takes about 100 cycles, so its in-progress reply can be seen
    reload_done <= (reload_wait == 1);
    if (reload_req === 1'b1)
    begin
      reload_cnt <= reload_cnt + 1;
      reload_wait <= 100;
    end
    else if (reload_wait > 0)
      reload_wait <= reload_wait - 1;
    if (mem_req === 1'b1 && !mem_ack)
    begin
      mem_cnt <= mem_cnt + 1;
      if (mem_cnt == mem_delay)
      begin
        mem_ack <= 1'b1;
        acks <= acks + 1;
        mem_rdata <= mem_addr ^ 8'h3C;
        seen_addr <= mem_addr;
        seen_wdata <= mem_wdata;
        seen_we <= mem_we;
      end
    end
    else
      mem_cnt <= 0;
    if (cyc == 40000)
    begin
      num_errors++;
      finish_test();
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Single AHB-Lite word transfer; waits on hready in both phases
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0, v);
    chk("register", v, exp);
    chk("response", {31'h0, hresp}, 32'h0);
  endtask
  // Reply seen in a frame belongs to the command of the frame before
  task automatic cmd(input logic [15:0] w, input logic [15:0] exp);
    m.xfer(w, 16, r);
    chk("reply", {16'h0, r}, {16'h0, exp});
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
    rdc(REG_CTRL, 32'h0);
    rdc(REG_STATUS, 32'h0);
    rdc(8'h0C, 32'h0);
    cmd(16'h0000, REPLY_IDLE);
    cmd(16'h0000, BOOT_UNREADY_REPLY);
    ahb(1'b1, REG_CTRL, 32'h1, v);
    rdc(REG_CTRL, 32'h1);
    cmd(16'h0000, BOOT_UNREADY_REPLY);
    // Every page code in turn; each reply after the first reports the page set one frame earlier
    for (int p = 0; p < 8; p++)
      cmd({CID_PAGE, 2'h0, 3'(p), 8'h00}, p == 0 ? REPLY_IDLE : {RID_PAGE, 2'h0, 3'(p - 1), 8'h00});
    cmd(16'h8300, 16'h8700);
    rdc(REG_STATUS, 32'h3);
    cmd(16'h45A5, 16'h8300);
    repeat (10) @(posedge hclk);
    chk("waddr", {24'h0, seen_addr}, 32'h65);
    chk("wdata", {24'h0, seen_wdata}, 32'hA5);
    chk("wdir", {31'h0, seen_we}, 32'h1);
    rdc(REG_LAST_CMD, 32'h45A5);
    cmd(16'h2500, 16'h45A5);
    cmd(16'h0000, 16'h2559);
    chk("rdir", {31'h0, seen_we}, 32'h0);
    // Slow memory: commands arriving while busy are dropped
    mem_delay = 400;
    cmd(16'h4111, REPLY_IDLE);
    cmd(16'h2200, REPLY_WRITE_WAIT);
    cmd(16'h0000, REPLY_WRITE_WAIT);
    rdc(REG_STATUS, 32'h2B);
    for (int n = 0; n < 1000 && mem_req !== 1'b0; n++)
      @(posedge hclk);
    // The read dropped while busy is sent again once the write has finished
    mem_delay = 2;
    cmd(16'h2200, 16'h4111);
    mem_delay = 400;
    cmd(16'h2300, 16'h225E);
    cmd(16'h0000, REPLY_READ_WAIT);
    cmd(16'h6000, REPLY_READ_WAIT);
    chk("cancel", {31'h0, mem_req}, 32'h0);
    cmd(16'h0000, ABORT_COMPLETE_REPLY);
    mem_delay = 2;
    v = 32'(acks);
    // Reserved codes and malformed frames give the error reply, no memory access
    // Reserved codes are sent on purpose here only
    cmd(16'hA000, REPLY_IDLE);
    cmd(16'hE000, REPLY_BUS_ERROR);
    cmd(16'h6001, REPLY_BUS_ERROR);
    m.xfer(16'h0000, 15, r);
    cmd(16'h0000, REPLY_BUS_ERROR);
    chk("accesses", 32'(acks), v);
    cmd(16'hC000, REPLY_IDLE);
    cmd(16'h0000, REPLY_IF_UNREADY);
    cmd(16'h0000, REPLY_IDLE);
    chk("reloads", 32'(reload_cnt), 32'h1);
    finish_test();
  end
endmodule
`default_nettype wire
